// File: gyro_spi_regs.svh
// Summary of operation
// - Chip select assertion snapshots rate data and fault flags.
// - After chip select release the answer for that command is loaded.
// - 32-bit frames; answer to frame N is shifted out during frame N+1.
// - Clock idles low; input sampled on rising edge, output changes on falling.
// - First exchange after reset returns 0x00000001.
// - Received sequence tag is echoed unchanged in the sensor response.
// - Module select field is always answered as 000.
// - Address bits of a sensor request are ignored.
// - Sensor response: tag, upper parity, content type, rate, faults, frame parity.
// - Read response heads 010, 1110 at 27:24, register data at 20:5.
// - Write response heads 001 and echoes the written 16-bit value.
// - Bad clock count or command parity gives error response with framing bit 20.
// - Content type 00 error, 01 rate, 10 self-test, 11 register access.
// - Gross self-test deviation or lock loss forces content type 00.
// - Command carries odd parity over all 32 bits; device checks it.
// - Upper parity makes response bits 31:16 odd.
// - Frame parity makes all 32 response bits odd.
// - Invalid command, missing register or read-only write raise bit 19.
// - Gap under 0.1 us between frames reports data unavailable in bit 18.
// - Fault flags stay set until reported; persisting faults set again at once.
// - Self-test fault position carries self-test OR resonance weak fault.
`ifndef GYRO_SPI_REGS_SVH
`define GYRO_SPI_REGS_SVH

`define FRAME_BITS 32
`define RESP_AFTER_RESET 32'h0000_0001
`define OP_READ 3'h4
`define OP_WRITE 3'h2
`define HEAD_READ 3'h2
`define HEAD_WRITE 3'h1
`define HEAD_ERROR 3'h0
`define RW_MARK 4'he
`define MODULE_SELECT_ANSWER 3'h0
`define CT_ERROR 2'h0
`define CT_RATE 2'h1
`define CT_SELFTEST 2'h2
`define CT_REGISTER 2'h3
`define SENSOR_MARK_BIT 29
`define TAG_HI_BIT 28
`define CHECK_REQ_BIT 1
`define ADDR_MSB 25
`define ADDR_LSB 17
`define PAYLOAD_MSB 16
`define PAYLOAD_LSB 1
// Times in ns; the gap is 0.1 us
`define CLK_PERIOD_NS 20
`define SEQ_GAP_NS 100
`define SEQ_GAP_CYC ((`SEQ_GAP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// File: gyro_spi_pkg.sv
package gyro_spi_pkg;
  typedef enum logic [1:0] {
    CMD_SENSOR = 2'h0,
    CMD_READ = 2'h1,
    CMD_WRITE = 2'h2,
    CMD_INVALID = 2'h3
  } cmd_kind_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_DECODE = 2'h1,
    ST_BUILD = 2'h2
  } ctl_state_t;

  typedef logic [31:0] frame_t;
endpackage : gyro_spi_pkg

// File: frame_link_if.sv
`timescale 1ns/1ps
interface frame_link_if;
  logic frame_start;
  logic frame_end;
  logic count_ok;
  gyro_spi_pkg::frame_t rx_word;
  gyro_spi_pkg::frame_t tx_word;

  modport engine (
    output frame_start,
    output frame_end,
    output count_ok,
    output rx_word,
    input tx_word
  );
  modport control (
    input frame_start,
    input frame_end,
    input count_ok,
    input rx_word,
    output tx_word
  );
endinterface : frame_link_if

// File: spi_shift_engine.sv
`timescale 1ns/1ps
`include "gyro_spi_regs.svh"
module spi_shift_engine (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  input wire logic clk_en,
  // Serial pins
  input wire logic sclk_pin,
  input wire logic cs_n_pin,
  input wire logic mosi_pin,
  output logic miso_o,
  output logic miso_oe,
  // Frame side
  frame_link_if.engine link
);
  logic [1:0] sclk_sync_reg;
  logic [1:0] cs_sync_reg;
  logic [1:0] mosi_sync_reg;
  logic sclk_last_reg;
  logic cs_last_reg;
  logic [5:0] bit_cnt_reg;
  logic [31:0] rx_shift_reg;
  logic [31:0] tx_shift_reg;
  logic sclk_rise;
  logic sclk_fall;
  logic cs_fall;
  logic cs_rise;
  logic cs_active;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      sclk_sync_reg <= 2'h0;
      cs_sync_reg <= 2'h3;
      mosi_sync_reg <= 2'h0;
      sclk_last_reg <= 1'b0;
      cs_last_reg <= 1'b1;
    end else if (clk_en) begin
      sclk_sync_reg <= {sclk_sync_reg[0], sclk_pin};
      cs_sync_reg <= {cs_sync_reg[0], cs_n_pin};
      mosi_sync_reg <= {mosi_sync_reg[0], mosi_pin};
      sclk_last_reg <= sclk_sync_reg[1];
      cs_last_reg <= cs_sync_reg[1];
    end
  end

  assign cs_active = ~cs_sync_reg[1];
  assign sclk_rise = sclk_sync_reg[1] & ~sclk_last_reg;
  assign sclk_fall = ~sclk_sync_reg[1] & sclk_last_reg;
  assign cs_fall = ~cs_sync_reg[1] & cs_last_reg;
  assign cs_rise = cs_sync_reg[1] & ~cs_last_reg;

  // Input sampled on rising edge, counter saturates so long frames stay wrong
  always_ff @(posedge core_clk) begin
    if (rst) begin
      bit_cnt_reg <= 6'h00;
      rx_shift_reg <= 32'h0000_0000;
    end else if (clk_en) begin
      if (cs_fall) begin
        bit_cnt_reg <= 6'h00;
      end else if (cs_active && sclk_rise) begin
        rx_shift_reg <= {rx_shift_reg[30:0], mosi_sync_reg[1]};
        if (bit_cnt_reg != 6'h3f) begin
          bit_cnt_reg <= bit_cnt_reg + 6'h01;
        end
      end
    end
  end

  // Output word taken at frame start, next bit moved out on falling edge
  always_ff @(posedge core_clk) begin
    if (rst) begin
      tx_shift_reg <= 32'h0000_0000;
    end else if (clk_en) begin
      if (cs_fall) begin
        tx_shift_reg <= link.tx_word;
      end else if (cs_active && sclk_fall) begin
        tx_shift_reg <= {tx_shift_reg[30:0], 1'b0};
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      miso_o <= 1'b0;
      miso_oe <= 1'b0;
    end else if (clk_en) begin
      miso_oe <= cs_active & ~cs_rise;
      miso_o <= cs_fall ? link.tx_word[31] : tx_shift_reg[31];
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      link.frame_start <= 1'b0;
      link.frame_end <= 1'b0;
      link.count_ok <= 1'b0;
      link.rx_word <= 32'h0000_0000;
    end else if (clk_en) begin
      link.frame_start <= cs_fall;
      link.frame_end <= cs_rise;
      if (cs_rise) begin
        link.rx_word <= rx_shift_reg;
        link.count_ok <= (bit_cnt_reg == 6'(`FRAME_BITS));
      end
    end
  end
endmodule : spi_shift_engine

// File: gyro_spi_slave.sv
`timescale 1ns/1ps
`include "gyro_spi_regs.svh"
module gyro_spi_slave (
  // Clock, reset, enable
  input wire logic core_clk,
  input wire logic rst,
  input wire logic clk_en,
  // Serial pins
  input wire logic sclk_pin,
  input wire logic cs_n_pin,
  input wire logic mosi_pin,
  output logic miso_o,
  output logic miso_oe,
  // Sensor data
  input wire logic [15:0] rate_data,
  input wire logic [15:0] selftest_data,
  input wire logic selftest_gross_fail,
  // Raw fault conditions
  input wire logic lock_loss_fault,
  input wire logic quadrature_fault,
  input wire logic stored_checksum_flag,
  input wire logic power_on_fault,
  input wire logic supply_fault_flag,
  input wire logic selftest_fault_flag,
  input wire logic resonance_weak_flag,
  // Register file port
  output logic [8:0] reg_addr,
  output logic reg_wr,
  output logic [15:0] reg_wr_data,
  input wire logic reg_exists,
  input wire logic reg_writable,
  input wire logic [15:0] reg_rd_data,
  // Status
  output logic self_check_request,
  output logic framing_error
);
  frame_link_if link ();

  spi_shift_engine engine_u (
    .core_clk(core_clk),
    .rst(rst),
    .clk_en(clk_en),
    .sclk_pin(sclk_pin),
    .cs_n_pin(cs_n_pin),
    .mosi_pin(mosi_pin),
    .miso_o(miso_o),
    .miso_oe(miso_oe),
    .link(link.engine)
  );

  gyro_spi_pkg::ctl_state_t state_reg;
  gyro_spi_pkg::cmd_kind_t kind_reg;
  gyro_spi_pkg::frame_t resp_reg;
  gyro_spi_pkg::frame_t cmd_reg;
  logic [6:0] sticky_reg;
  logic [6:0] fault_snap_reg;
  logic [15:0] rate_snap_reg;
  logic [15:0] selftest_snap_reg;
  logic gross_snap_reg;
  logic lock_snap_reg;
  logic spi_err_reg;
  logic ready_reg;
  logic du_pending_reg;
  logic du_frame_reg;
  logic [3:0] gap_cnt_reg;
  logic [6:0] fault_raw;
  logic [2:0] seq_tag;
  logic cmd_parity_ok;
  logic rw_bad;
  gyro_spi_pkg::frame_t resp_next;

  // Fault bits 6:1 in response order, sent at response bits 7:2; check bit is echoed separately
  assign fault_raw = {lock_loss_fault, quadrature_fault, stored_checksum_flag,
    power_on_fault, supply_fault_flag, selftest_fault_flag | resonance_weak_flag,
    1'b0};

  assign seq_tag = {cmd_reg[`TAG_HI_BIT], cmd_reg[31:30]};
  assign cmd_parity_ok = ^link.rx_word;

  // Set wins over the clear of reported bits
  always_ff @(posedge core_clk) begin
    if (rst) begin
      sticky_reg <= 7'h00;
    end else if (clk_en) begin
      if (state_reg == gyro_spi_pkg::ST_BUILD && kind_reg == gyro_spi_pkg::CMD_SENSOR) begin
        sticky_reg <= (sticky_reg & ~fault_snap_reg) | fault_raw;
      end else begin
        sticky_reg <= sticky_reg | fault_raw;
      end
    end
  end

  // Snapshot on chip select assertion; the answer may be arbitrarily old
  always_ff @(posedge core_clk) begin
    if (rst) begin
      fault_snap_reg <= 7'h00;
      rate_snap_reg <= 16'h0000;
      selftest_snap_reg <= 16'h0000;
      gross_snap_reg <= 1'b0;
      lock_snap_reg <= 1'b0;
    end else if (clk_en && link.frame_start) begin
      fault_snap_reg <= sticky_reg | fault_raw;
      rate_snap_reg <= rate_data;
      selftest_snap_reg <= selftest_data;
      gross_snap_reg <= selftest_gross_fail;
      lock_snap_reg <= lock_loss_fault;
    end
  end

  // Gap timer between frames for the data unavailable report
  always_ff @(posedge core_clk) begin
    if (rst) begin
      gap_cnt_reg <= 4'hf;
    end else if (clk_en) begin
      if (link.frame_end) begin
        gap_cnt_reg <= 4'h0;
      end else if (gap_cnt_reg != 4'hf) begin
        gap_cnt_reg <= gap_cnt_reg + 4'h1;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      du_pending_reg <= 1'b0;
      du_frame_reg <= 1'b0;
    end else if (clk_en) begin
      if (link.frame_start) begin
        du_pending_reg <= ~ready_reg || (gap_cnt_reg < 4'(`SEQ_GAP_CYC));
      end
      if (link.frame_end) begin
        du_frame_reg <= du_pending_reg;
      end
    end
  end

  // Command capture and decode at frame end
  always_ff @(posedge core_clk) begin
    if (rst) begin
      cmd_reg <= 32'h0000_0000;
      kind_reg <= gyro_spi_pkg::CMD_INVALID;
      spi_err_reg <= 1'b0;
      reg_addr <= 9'h000;
    end else if (clk_en && link.frame_end) begin
      cmd_reg <= link.rx_word;
      spi_err_reg <= ~link.count_ok | ~cmd_parity_ok;
      reg_addr <= link.rx_word[`ADDR_MSB:`ADDR_LSB];
      if (link.rx_word[`SENSOR_MARK_BIT]) begin
        kind_reg <= gyro_spi_pkg::CMD_SENSOR;
      end else if (link.rx_word[31:29] == `OP_READ) begin
        kind_reg <= gyro_spi_pkg::CMD_READ;
      end else if (link.rx_word[31:29] == `OP_WRITE) begin
        kind_reg <= gyro_spi_pkg::CMD_WRITE;
      end else begin
        kind_reg <= gyro_spi_pkg::CMD_INVALID;
      end
    end
  end

  // Register lookup at the build step uses the address registered two cycles earlier
  assign rw_bad = (kind_reg == gyro_spi_pkg::CMD_INVALID) ||
    ((kind_reg == gyro_spi_pkg::CMD_READ || kind_reg == gyro_spi_pkg::CMD_WRITE) &&
    !reg_exists) || (kind_reg == gyro_spi_pkg::CMD_WRITE && !reg_writable);

  always_comb begin
    logic [1:0] ctype;
    ctype = `CT_RATE;
    resp_next = 32'h0000_0000;
    if (spi_err_reg || rw_bad || du_frame_reg) begin
      // Error answer regardless of the command type
      resp_next = {`HEAD_ERROR, 1'b0, `RW_MARK, `MODULE_SELECT_ANSWER,
        spi_err_reg, rw_bad & ~spi_err_reg, du_frame_reg, 10'h000,
        fault_snap_reg[6:1], cmd_reg[`CHECK_REQ_BIT], 1'b0};
    end else if (kind_reg == gyro_spi_pkg::CMD_SENSOR) begin
      if (gross_snap_reg || lock_snap_reg) begin
        ctype = `CT_ERROR;
      end else if (cmd_reg[`CHECK_REQ_BIT]) begin
        ctype = `CT_SELFTEST;
      end else begin
        ctype = `CT_RATE;
      end
      resp_next = {seq_tag, 1'b0, ctype,
        (ctype == `CT_SELFTEST) ? selftest_snap_reg : rate_snap_reg, 2'h0,
        fault_snap_reg[6:1], cmd_reg[`CHECK_REQ_BIT], 1'b0};
    end else if (kind_reg == gyro_spi_pkg::CMD_READ) begin
      resp_next = {`HEAD_READ, 1'b0, `RW_MARK, `MODULE_SELECT_ANSWER,
        reg_rd_data, 4'h0, 1'b0};
    end else begin
      resp_next = {`HEAD_WRITE, 1'b0, `RW_MARK, `MODULE_SELECT_ANSWER,
        cmd_reg[`PAYLOAD_MSB:`PAYLOAD_LSB], 4'h0, 1'b0};
    end
    resp_next[28] = ~(^resp_next[31:16]);
    resp_next[0] = ~(^resp_next[31:1]);
  end

  // Sequencer: decode, then build and load the answer for the next frame
  always_ff @(posedge core_clk) begin
    if (rst) begin
      state_reg <= gyro_spi_pkg::ST_IDLE;
      ready_reg <= 1'b1;
    end else if (clk_en) begin
      case (state_reg)
        gyro_spi_pkg::ST_IDLE: begin
          if (link.frame_end) begin
            state_reg <= gyro_spi_pkg::ST_DECODE;
            ready_reg <= 1'b0;
          end
        end
        gyro_spi_pkg::ST_DECODE: begin
          state_reg <= gyro_spi_pkg::ST_BUILD;
        end
        gyro_spi_pkg::ST_BUILD: begin
          state_reg <= gyro_spi_pkg::ST_IDLE;
          ready_reg <= 1'b1;
        end
        default: begin
          state_reg <= gyro_spi_pkg::ST_IDLE;
          ready_reg <= 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      resp_reg <= `RESP_AFTER_RESET;
    end else if (clk_en && state_reg == gyro_spi_pkg::ST_BUILD) begin
      resp_reg <= resp_next;
    end
  end

  assign link.tx_word = resp_reg;

  // Register write strobe only for a clean write to a writable register
  always_ff @(posedge core_clk) begin
    if (rst) begin
      reg_wr <= 1'b0;
      reg_wr_data <= 16'h0000;
    end else if (clk_en) begin
      reg_wr <= (state_reg == gyro_spi_pkg::ST_BUILD) &&
        kind_reg == gyro_spi_pkg::CMD_WRITE && !spi_err_reg && !rw_bad && !du_frame_reg;
      // Payload settles a cycle ahead so it already stands when the strobe rises
      if (state_reg == gyro_spi_pkg::ST_DECODE) begin
        reg_wr_data <= cmd_reg[`PAYLOAD_MSB:`PAYLOAD_LSB];
      end
    end
  end

  // Framing flag follows every command; check request the last sensor command without SPI error
  always_ff @(posedge core_clk) begin
    if (rst) begin
      self_check_request <= 1'b0;
      framing_error <= 1'b0;
    end else if (clk_en && state_reg == gyro_spi_pkg::ST_BUILD) begin
      framing_error <= spi_err_reg;
      if (!spi_err_reg && kind_reg == gyro_spi_pkg::CMD_SENSOR) begin
        self_check_request <= cmd_reg[`CHECK_REQ_BIT];
      end
    end
  end
endmodule : gyro_spi_slave

// File: gyro_spi_slave_checker.sv
`timescale 1ns/1ps
module gyro_spi_slave_checker (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Serial pins
  input wire logic sclk_pin,
  input wire logic cs_n_pin,
  input wire logic miso_o,
  input wire logic miso_oe,
  // Register port and status
  input wire logic [8:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [15:0] reg_wr_data,
  input wire logic reg_exists,
  input wire logic reg_writable,
  input wire logic framing_error
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);
  // Windows leave room for the two-flop pin synchronisers
  sequence idle_s;
    cs_n_pin [*6];
  endsequence
  sequence busy_s;
    !cs_n_pin [*8];
  endsequence
  oe_idle_a: assert property (idle_s |-> !miso_oe)
    else $error("miso driven outside a frame");
  oe_busy_a: assert property (busy_s |-> miso_oe)
    else $error("miso released inside a frame");
  wr_single_a: assert property (reg_wr |=> !reg_wr)
    else $error("write strobe longer than one cycle");
  wr_after_cs_a: assert property (reg_wr |-> cs_n_pin && $past(cs_n_pin, 4))
    else $error("write strobe before chip select release");
  wr_target_a: assert property (reg_wr |-> reg_exists && reg_writable)
    else $error("write to missing or read-only register");
  wr_hold_a: assert property (reg_wr |-> $stable(reg_addr) && $stable(reg_wr_data))
    else $error("write address or data moved at strobe");
  addr_hold_a: assert property (busy_s |-> $stable(reg_addr))
    else $error("register address moved inside a frame");
  err_hold_a: assert property (busy_s |-> $stable(framing_error))
    else $error("framing flag moved inside a frame");
  miso_edge_a: assert property ($changed(miso_o) && $past(miso_oe) && miso_oe
    |-> !$past(sclk_pin, 2))
    else $error("miso changed after a rising serial clock");
endmodule : gyro_spi_slave_checker

bind gyro_spi_slave gyro_spi_slave_checker u_checker (
  .core_clk(core_clk), .rst(rst), .sclk_pin(sclk_pin), .cs_n_pin(cs_n_pin),
  .miso_o(miso_o), .miso_oe(miso_oe), .reg_addr(reg_addr), .reg_wr(reg_wr),
  .reg_wr_data(reg_wr_data), .reg_exists(reg_exists), .reg_writable(reg_writable),
  .framing_error(framing_error)
);

// File: spi_host_model.sv
`timescale 1ns/1ps
module spi_host_model (
  // Clock
  input wire logic core_clk,
  // Serial pins
  output logic sclk_pin,
  output logic cs_n_pin,
  output logic mosi_pin,
  input wire logic miso_line,
  // Result
  output gyro_spi_pkg::frame_t resp,
  output logic done
);
  initial begin
    sclk_pin = 1'b0;
    cs_n_pin = 1'b1;
    mosi_pin = 1'b0;
    resp = '0;
    done = 1'b0;
  end
  // Serial clock of 8 core cycles; it stands low between frames
  task automatic xfer(input gyro_spi_pkg::frame_t cmd, input int nclk);
    gyro_spi_pkg::frame_t r;
    r = '0;
    @(posedge core_clk);
    cs_n_pin <= 1'b0;
    mosi_pin <= cmd[31];
    repeat (4) @(posedge core_clk);
    for (int i = 0; i < nclk; i++) begin
      sclk_pin <= 1'b1;
      repeat (4) @(posedge core_clk);
      r = {r[30:0], miso_line};
      sclk_pin <= 1'b0;
      mosi_pin <= (i < 31) ? cmd[30 - i] : ~cmd[0];
      repeat (4) @(posedge core_clk);
    end
    cs_n_pin <= 1'b1;
    // Released data line flips once more, so after 32 clocks it shows the last bit cmd[0] again
    mosi_pin <= ~mosi_pin;
    resp <= r;
    done <= 1'b1;
    @(posedge core_clk);
    done <= 1'b0;
  endtask : xfer
endmodule : spi_host_model

// File: tb_gyro_spi_slave.sv
`timescale 1ns/1ps
`define CMP(nm, ex, got) begin n_compared++; if ((got) !== (ex)) begin fails++; \
  $display("[FAIL] %s expected %h seen %h", nm, ex, got); end end
module tb_gyro_spi_slave;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic clk_en = 1'b1;
  logic sclk_pin, cs_n_pin, mosi_pin, miso_o, miso_oe, miso_line, done, reg_wr;
  logic reg_exists, reg_writable, self_check_request, framing_error;
  logic [15:0] rate_data, selftest_data, reg_wr_data, reg_rd_data;
  logic gross, lock, quad, stored, pwr_on, supply, st_flag, res_flag;
  logic [8:0] reg_addr;
  logic [15:0] lfsr_reg = 16'h0035;
  gyro_spi_pkg::frame_t resp;
  gyro_spi_pkg::frame_t exp_q[$];
  gyro_spi_pkg::frame_t msk_q[$];
  int fails = 0;
  int n_compared = 0;
  int wr_count = 0;
  localparam gyro_spi_pkg::frame_t FULL = 32'hffff_ffff;
  localparam gyro_spi_pkg::frame_t ERRM = 32'hefff_fffc;
  localparam gyro_spi_pkg::frame_t ERRE = 32'h0e00_0000;

  always #10 core_clk = ~core_clk;
  assign miso_line = miso_oe ? miso_o : 1'b1;
  assign reg_exists = reg_addr < 9'h040;
  assign reg_writable = !reg_addr[5];
  assign reg_rd_data = {7'h00, reg_addr} ^ 16'h5a3c;

  spi_host_model host (.core_clk(core_clk), .sclk_pin(sclk_pin), .cs_n_pin(cs_n_pin),
    .mosi_pin(mosi_pin), .miso_line(miso_line), .resp(resp), .done(done));
  gyro_spi_slave DUT (.core_clk(core_clk), .rst(rst), .clk_en(clk_en),
    .sclk_pin(sclk_pin), .cs_n_pin(cs_n_pin), .mosi_pin(mosi_pin), .miso_o(miso_o),
    .miso_oe(miso_oe), .rate_data(rate_data), .selftest_data(selftest_data),
    .selftest_gross_fail(gross), .lock_loss_fault(lock), .quadrature_fault(quad),
    .stored_checksum_flag(stored), .power_on_fault(pwr_on), .supply_fault_flag(supply),
    .selftest_fault_flag(st_flag), .resonance_weak_flag(res_flag), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_wr_data(reg_wr_data), .reg_exists(reg_exists),
    .reg_writable(reg_writable), .reg_rd_data(reg_rd_data),
    .self_check_request(self_check_request), .framing_error(framing_error));

  function automatic logic [15:0] lfsr_next();
    lfsr_reg = {lfsr_reg[14:0], lfsr_reg[15] ^ lfsr_reg[13] ^ lfsr_reg[12] ^ lfsr_reg[10]};
    return lfsr_reg;
  endfunction : lfsr_next
  function automatic gyro_spi_pkg::frame_t par(gyro_spi_pkg::frame_t w);
    w[28] = ~^{w[31:29], w[27:16]};
    w[0] = ~^w[31:1];
    return w;
  endfunction : par
  function automatic gyro_spi_pkg::frame_t sens_cmd(logic [2:0] tag, logic chk);
    logic [15:0] j;
    gyro_spi_pkg::frame_t w;
    j = lfsr_next();
    w = {tag[1:0], 1'b1, tag[2], j, j[9:0], chk, 1'b0};
    w[0] = ~^w[31:1];
    return w;
  endfunction : sens_cmd
  function automatic gyro_spi_pkg::frame_t errx(logic [2:0] fl);
    return ERRE | {11'h000, fl, 18'h00000};
  endfunction : errx
  function automatic gyro_spi_pkg::frame_t sens_exp(logic [2:0] tag, logic [1:0] ct,
      logic [15:0] d, logic [5:0] f6, logic chk);
    return par({tag, 1'b0, ct, d, 2'h0, f6, chk, 1'b0});
  endfunction : sens_exp
  function automatic gyro_spi_pkg::frame_t rw_cmd(logic [2:0] op, logic [8:0] a, logic [15:0] d);
    gyro_spi_pkg::frame_t w;
    w = {op, 3'h5, a, d, 1'b0};
    w[0] = ~^w[31:1];
    return w;
  endfunction : rw_cmd
  function automatic gyro_spi_pkg::frame_t rw_exp(logic [2:0] hd, logic [15:0] d);
    return par({hd, 1'b0, 4'he, 3'h0, d, 5'h00});
  endfunction : rw_exp

  task automatic frame(input gyro_spi_pkg::frame_t cmd, input int nclk, input int gap,
      input gyro_spi_pkg::frame_t ex, input gyro_spi_pkg::frame_t mk);
    exp_q.push_back(ex);
    msk_q.push_back(mk);
    fork
      host.xfer(cmd, nclk);
      begin
        // Samples move mid-frame; the answer must keep the start-of-frame copy
        repeat (10) @(posedge core_clk);
        rate_data <= lfsr_next();
        selftest_data <= lfsr_next();
      end
    join
    repeat (gap) @(posedge core_clk);
  endtask : frame
  task automatic sensor(input logic [2:0] tag, input logic chk, input logic [1:0] ct,
      input logic [5:0] f6, input gyro_spi_pkg::frame_t mk);
    frame(sens_cmd(tag, chk), 32, 6,
      sens_exp(tag, ct, chk ? selftest_data : rate_data, f6, chk), mk);
  endtask : sensor
  task print_verdict();
    if (fails == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : print_verdict

  always @(posedge core_clk) begin
    if (done === 1'b1) begin
      `CMP("response", exp_q[0] & msk_q[0], resp & msk_q[0])
      if (msk_q[0][31] && exp_q[0] !== 32'h0000_0001) begin
        `CMP("upper parity", 1'b1, ^resp[31:16])
        `CMP("frame parity", 1'b1, ^resp)
      end
      void'(exp_q.pop_front());
      void'(msk_q.pop_front());
    end
    if (reg_wr === 1'b1) wr_count++;
  end

  initial begin
    repeat (40000) @(posedge core_clk);
    fails++;
    print_verdict();
  end

  initial begin
    logic [15:0] f;
    {gross, lock, quad, stored, pwr_on, supply, st_flag, res_flag} = 8'h00;
    rate_data = 16'h1234;
    selftest_data = 16'h0f0f;
    repeat (8) @(posedge core_clk);
    rst <= 1'b0;
    repeat (4) @(posedge core_clk);
    exp_q.push_back(32'h0000_0001);
    msk_q.push_back(FULL);
    for (int t = 0; t < 8; t++) sensor(3'(t), 1'b0, 2'h1, 6'h00, FULL);
    sensor(3'h2, 1'b1, 2'h2, 6'h00, FULL);
    `CMP("check request", 1'b1, self_check_request)
    gross <= 1'b1;
    sensor(3'h3, 1'b0, 2'h0, 6'h00, FULL);
    gross <= 1'b0;
    lock <= 1'b1;
    sensor(3'h4, 1'b0, 2'h0, 6'h20, FULL);
    lock <= 1'b0;
    sensor(3'h5, 1'b0, 2'h1, 6'h20, 32'he3ff_fffe);
    sensor(3'h6, 1'b0, 2'h1, 6'h00, FULL);
    repeat (4) begin
      f = lfsr_next();
      {quad, stored, pwr_on, supply, st_flag, res_flag} <= f[5:0];
      repeat (2) @(posedge core_clk);
      {quad, stored, pwr_on, supply, st_flag, res_flag} <= 6'h00;
      sensor(f[8:6], 1'b0, 2'h1, {1'b0, f[5:2], f[1] | f[0]}, FULL);
    end
    f = lfsr_next();
    frame(rw_cmd(3'h2, 9'h012, f), 32, 10, rw_exp(3'h1, f), FULL);
    `CMP("write data", f, reg_wr_data)
    `CMP("write address", 9'h012, reg_addr)
    frame(rw_cmd(3'h4, 9'h023, 16'h0000), 32, 10, rw_exp(3'h2, 16'h5a1f), FULL);
    frame(rw_cmd(3'h2, 9'h025, f), 32, 10, errx(3'h2), ERRM);
    frame(rw_cmd(3'h2, 9'h1f0, f), 32, 10, errx(3'h2), ERRM);
    frame(rw_cmd(3'h6, 9'h000, f), 32, 10, errx(3'h2), ERRM);
    `CMP("framing flag", 1'b0, framing_error)
    frame(rw_cmd(3'h2, 9'h012, f) ^ 32'h1, 32, 10, errx(3'h4), ERRM);
    `CMP("framing flag", 1'b1, framing_error)
    // The short frame that follows sees only bits 31:1 of this answer
    frame(sens_cmd(3'h1, 1'b0), 32, 6,
      sens_exp(3'h1, 2'h1, rate_data, 6'h00, 1'b0) >> 1, 32'h7fff_ffff);
    frame(sens_cmd(3'h7, 1'b0), 31, 10, errx(3'h4), ERRM);
    `CMP("framing flag", 1'b1, framing_error)
    // Gap below the minimum, yet long enough for this answer to be loaded in time
    frame(sens_cmd(3'h1, 1'b0), 32, 2, sens_exp(3'h1, 2'h1, rate_data, 6'h00, 1'b0), FULL);
    frame(sens_cmd(3'h2, 1'b0), 32, 10, errx(3'h1), ERRM);
    frame(sens_cmd(3'h0, 1'b0), 32, 10, 32'h0, 32'h0);
    `CMP("write strobes", 1, wr_count)
    print_verdict();
  end
endmodule : tb_gyro_spi_slave
